/* rtl/wwc_pkg.sv */
package wwc_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam int unsigned WWC_AW = 8;
   localparam logic [7:0] WWC_OFF_CTRL = 8'h00;
   localparam logic [7:0] WWC_OFF_FLAGS = 8'h04;
   localparam logic [7:0] WWC_OFF_STAT = 8'h08;
   localparam logic [7:0] WWC_OFF_WAKE = 8'h0c;
   localparam logic [7:0] WWC_OFF_CFG = 8'h10;

   // ****************************************
   // fields and reset values
   // ****************************************
   localparam logic [4:0] WWC_KEY_DIS = 5'h15;
   localparam logic [4:0] WWC_KEY_EN = 5'h0a;
   localparam logic [2:0] WWC_TSEL_POR = 3'h3;
   localparam logic [7:0] WWC_CTRL_POR = {WWC_KEY_EN, WWC_TSEL_POR};
   localparam int unsigned WWC_KEY_LSB = 3;
   localparam int unsigned WWC_FLG_KEYRST = 0;
   localparam int unsigned WWC_FLG_IDLEKEEP = 7;
   localparam int unsigned WWC_CFG_XTAL = 0;
   localparam int unsigned WWC_CFG_LVD = 1;
   localparam logic [7:0] WWC_WAKE_POR = 8'h00;
   localparam logic [1:0] WWC_CFG_POR = 2'h0;
   localparam logic [1:0] WWC_RESP_OK = 2'h0;
   localparam logic [1:0] WWC_RESP_ERR = 2'h2;

   // ****************************************
   // timing counts
   // ****************************************
   localparam int unsigned WWC_CNT_W = 18;
   localparam logic [10:0] WWC_FAST_SST = 11'h400;
   localparam logic [10:0] WWC_SLOW_SST = 11'h400;
   localparam logic [1:0] WWC_KEY_RST_TICKS = 2'h3;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      WWC_RUN = 3'h0, WWC_DEEP = 3'h1, WWC_SLEEP_SUB = 3'h2, WWC_IDLE_OFF = 3'h3, WWC_IDLE_ON = 3'h4
   } wwc_mode_e;
   typedef enum logic [1:0] {WWC_SST_DONE = 2'h0, WWC_SST_FAST = 2'h1, WWC_SST_SLOW = 2'h2} wwc_sst_e;
   typedef enum logic [2:0] {
      WWC_WK_NONE = 3'h0, WWC_WK_RESUME = 3'h1, WWC_WK_VECTOR = 3'h2, WWC_WK_PCSP = 3'h3, WWC_WK_RESET = 3'h4
   } wwc_wake_e;

   typedef struct packed {
      logic awvalid;
      logic [WWC_AW-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [WWC_AW-1:0] araddr;
      logic rready;
   } wwc_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } wwc_axi_rsp_s;

   // overflow mask: all ones below the selected period bit
   function automatic logic [WWC_CNT_W-1:0] wwc_period_mask(input logic [2:0] sel);
      case (sel)
         3'h0: wwc_period_mask = 18'h000ff;
         3'h1: wwc_period_mask = 18'h003ff;
         3'h2: wwc_period_mask = 18'h00fff;
         3'h3: wwc_period_mask = 18'h03fff;
         3'h4: wwc_period_mask = 18'h07fff;
         3'h5: wwc_period_mask = 18'h0ffff;
         3'h6: wwc_period_mask = 18'h1ffff;
         default: wwc_period_mask = 18'h3ffff;
      endcase
   endfunction

endpackage

/* rtl/wwc_top.sv */
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps

// Behaviour
// - count the selected low-speed sub clock
// - select field picks period 2^8..2^18
// - key 10101 disables, 01010 enables
// - other key resets device after 2~3 ticks
// - key reset sets key reset flag
// - key reset flag cleared only by software
// - power-on: key 01010, select 011
// - running overflow resets device, sets timeout
// - sleeping overflow wakes, resets pc/sp only
// - key reset, clear, halt clear counter
// - power-down flag: halt sets, clear clears
// - four wake sources leave sleep or idle
// - per-pin port A falling-edge wake enable
// - disabled or stack-full irq resumes after halt
// - enabled irq with free stack vectors
// - irq pending at entry cannot wake
// - crystals share one start-up counter, fast first
// - deep wake runs only after fast ready
// - sub clock stops only in deepest sleep
// - entering sub-clock sleep clears, resumes counting
module wwc_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire wwc_pkg::wwc_axi_req_s axi_req,
   output wwc_pkg::wwc_axi_rsp_s axi_rsp,
   // low-speed oscillator pins
   input wire logic slow_crystal_osc,
   input wire logic slow_rc_osc,
   // processor side
   input wire logic clear_watchdog_instruction,
   input wire logic halt_instruction,
   input wire logic idle_mode_sel,
   input wire logic [7:0] irq_req,
   input wire logic [7:0] irq_en,
   input wire logic stack_full,
   // wake pins
   input wire logic [7:0] porta_in,
   input wire logic ext_reset_n,
   // control outputs
   output logic dev_reset,
   output logic pc_sp_reset,
   output logic wake_resume,
   output logic wake_vector,
   output logic cpu_run,
   output logic fast_osc_ready_flag
);
   import wwc_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   logic [1:0] osc_s1_r, osc_s2_r, osc_s3_r;
   logic [7:0] pa_s1_r, pa_s2_r, pa_s3_r;
   logic ext_s1_r, ext_s2_r;
   logic [7:0] ctrl_r, ctrl_nxt;
   logic idle_keep_r, key_flag_r, key_flag_nxt;
   logic [7:0] wake_en_r;
   logic [1:0] cfg_r;
   logic [WWC_CNT_W-1:0] cnt_r, cnt_nxt;
   logic [1:0] key_cnt_r;
   wwc_mode_e mode_r, mode_nxt, halt_mode;
   wwc_sst_e sst_r, sst_nxt;
   wwc_wake_e pend_r, pend_nxt, wake_kind;
   logic [10:0] sst_cnt_r, sst_cnt_nxt;
   logic fast_rdy_r, fast_rdy_nxt, slow_rdy_r, slow_rdy_nxt;
   logic to_r, pdf_r;
   logic [7:0] irq_mask_r;
   logic aw_got_r, w_got_r;
   logic [WWC_AW-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;

   // ****************************************
   // pin synchronisers
   // ****************************************
   // the first stage feeds only the second; edges are taken between stages two and three
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_s1_r <= 2'h0;
         osc_s2_r <= 2'h0;
         osc_s3_r <= 2'h0;
         pa_s1_r <= 8'hff;
         pa_s2_r <= 8'hff;
         pa_s3_r <= 8'hff;
         ext_s1_r <= 1'h1;
         ext_s2_r <= 1'h1;
      end else begin
         osc_s1_r <= {slow_crystal_osc, slow_rc_osc};
         osc_s2_r <= osc_s1_r;
         osc_s3_r <= osc_s2_r;
         pa_s1_r <= porta_in;
         pa_s2_r <= pa_s1_r;
         pa_s3_r <= pa_s2_r;
         ext_s1_r <= ext_reset_n;
         ext_s2_r <= ext_s1_r;
      end
   end

   // ****************************************
   // sub clock and watchdog decode
   // ****************************************
   wire running = (mode_r == WWC_RUN);
   wire sleeping = !running;
   wire src_xtal = cfg_r[WWC_CFG_XTAL];
   wire lvd_en = cfg_r[WWC_CFG_LVD];
   wire [4:0] key = ctrl_r[7:WWC_KEY_LSB];
   wire [2:0] tsel = ctrl_r[2:0];
   wire sub_run = (mode_r != WWC_DEEP);
   // one-cycle enable per rising edge of the chosen oscillator
   wire sub_tick = sub_run && osc_s2_r[src_xtal] && !osc_s3_r[src_xtal];
   wire wdt_on = (key == WWC_KEY_EN);
   wire key_bad = (key != WWC_KEY_EN) && (key != WWC_KEY_DIS);
   wire [WWC_CNT_W-1:0] pmask = wwc_period_mask(tsel);
   wire ovf = wdt_on && sub_tick && ((cnt_r & pmask) == pmask);
   // third tick after a bad key lands 2~3 sub periods after it appeared
   wire key_fire = key_bad && sub_tick && (key_cnt_r == WWC_KEY_RST_TICKS - 2'h1);
   wire clr_instr = clear_watchdog_instruction && running;
   wire halt_go = halt_instruction && running;

   // ****************************************
   // wake sources
   // ****************************************
   wire [7:0] pa_fall = pa_s3_r & ~pa_s2_r & wake_en_r;
   wire [7:0] irq_fresh = irq_req & ~irq_mask_r;
   wire irq_vec = |(irq_fresh & irq_en) && !stack_full;
   wire ext_low = !ext_s2_r;
   wire wake_any = sleeping && (ext_low || ovf || (|pa_fall) || (|irq_fresh));
   assign wake_kind = ext_low ? WWC_WK_RESET :
                      ovf ? WWC_WK_PCSP :
                      irq_vec ? WWC_WK_VECTOR : WWC_WK_RESUME;
   assign halt_mode = idle_mode_sel ? (idle_keep_r ? WWC_IDLE_ON : WWC_IDLE_OFF) :
                      ((wdt_on || lvd_en) ? WWC_SLEEP_SUB : WWC_DEEP);
   assign mode_nxt = halt_go ? halt_mode : (wake_any ? WWC_RUN : mode_r);
   // the wake action waits in pend_r until the fast oscillator is ready
   wire fire = (pend_r != WWC_WK_NONE) && fast_rdy_r;
   assign pend_nxt = wake_any ? wake_kind : (fire ? WWC_WK_NONE : pend_r);

   // ****************************************
   // watchdog counter
   // ****************************************
   // halt clears it; it keeps counting in sleep modes that hold the sub clock
   assign cnt_nxt = (key_fire || clr_instr || halt_go || ovf || !wdt_on) ? '0 :
                    (sub_tick ? cnt_r + 18'h00001 : cnt_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= '0;
         key_cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_nxt;
         key_cnt_r <= (!key_bad || key_fire) ? 2'h0 : (sub_tick ? key_cnt_r + 2'h1 : key_cnt_r);
      end
   end

   // ****************************************
   // mode and status flags
   // ****************************************
   // hardware sets win over same-cycle clears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= WWC_RUN;
         pend_r <= WWC_WK_NONE;
         to_r <= 1'h0;
         pdf_r <= 1'h0;
         irq_mask_r <= 8'h00;
      end else begin
         mode_r <= mode_nxt;
         pend_r <= pend_nxt;
         to_r <= ovf || (to_r && !(clr_instr || halt_go));
         pdf_r <= halt_go || (pdf_r && !clr_instr);
         irq_mask_r <= halt_go ? irq_req : irq_mask_r;
      end
   end

   // ****************************************
   // shared start-up stabilise counter
   // ****************************************
   // fast crystal first, then the slow crystal reuses the same counter
   always_comb begin
      sst_nxt = sst_r;
      sst_cnt_nxt = sst_cnt_r;
      fast_rdy_nxt = fast_rdy_r;
      slow_rdy_nxt = slow_rdy_r;
      case (sst_r)
         WWC_SST_DONE: begin
            if (halt_go && (halt_mode == WWC_DEEP)) begin
               fast_rdy_nxt = 1'h0;
               slow_rdy_nxt = !src_xtal;
            end else if (wake_any && (mode_r == WWC_DEEP)) begin
               sst_nxt = WWC_SST_FAST;
               sst_cnt_nxt = 11'h000;
            end
         end
         WWC_SST_FAST: begin
            sst_cnt_nxt = sst_cnt_r + 11'h001;
            if (sst_cnt_r == WWC_FAST_SST - 11'h001) begin
               fast_rdy_nxt = 1'h1;
               sst_nxt = WWC_SST_SLOW;
               sst_cnt_nxt = 11'h000;
            end
         end
         WWC_SST_SLOW: begin
            // the internal rc needs no stabilise period
            if (!src_xtal) begin
               slow_rdy_nxt = 1'h1;
               sst_nxt = WWC_SST_DONE;
            end else if (sub_tick) begin
               sst_cnt_nxt = sst_cnt_r + 11'h001;
               if (sst_cnt_r == WWC_SLOW_SST - 11'h001) begin
                  slow_rdy_nxt = 1'h1;
                  sst_nxt = WWC_SST_DONE;
               end
            end
         end
         default: begin
            sst_nxt = WWC_SST_DONE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sst_r <= WWC_SST_SLOW;
         sst_cnt_r <= 11'h000;
         fast_rdy_r <= 1'h1;
         slow_rdy_r <= 1'h0;
      end else begin
         sst_r <= sst_nxt;
         sst_cnt_r <= sst_cnt_nxt;
         fast_rdy_r <= fast_rdy_nxt;
         slow_rdy_r <= slow_rdy_nxt;
      end
   end

   // ****************************************
   // control outputs
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dev_reset <= 1'h0;
         pc_sp_reset <= 1'h0;
         wake_resume <= 1'h0;
         wake_vector <= 1'h0;
         cpu_run <= 1'h0;
         fast_osc_ready_flag <= 1'h0;
      end else begin
         dev_reset <= key_fire || (ovf && running) || (fire && pend_r == WWC_WK_RESET);
         pc_sp_reset <= fire && (pend_r == WWC_WK_PCSP);
         wake_resume <= fire && (pend_r == WWC_WK_RESUME);
         wake_vector <= fire && (pend_r == WWC_WK_VECTOR);
         cpu_run <= running && fast_rdy_r && (pend_r == WWC_WK_NONE);
         fast_osc_ready_flag <= fast_rdy_r;
      end
   end

   // ****************************************
   // register bus decode
   // ****************************************
   wire aw_take = axi_req.awvalid && axi_rsp.awready;
   wire w_take = axi_req.wvalid && axi_rsp.wready;
   wire ar_take = axi_req.arvalid && axi_rsp.arready;
   // a new write lands only once the previous response has gone
   wire do_write = aw_got_r && w_got_r && !axi_rsp.bvalid;
   wire aw_got_nxt = !do_write && (aw_got_r || aw_take);
   wire w_got_nxt = !do_write && (w_got_r || w_take);
   wire b_done = axi_rsp.bvalid && axi_req.bready;
   // read data is sampled at the address edge, so status is one cycle old when seen
   wire rd_done = axi_rsp.rvalid && axi_req.rready;
   wire wr_ctrl = do_write && w_strb_r[0] && (aw_addr_r == WWC_OFF_CTRL);
   wire wr_flags = do_write && w_strb_r[0] && (aw_addr_r == WWC_OFF_FLAGS);
   wire wr_wake = do_write && w_strb_r[0] && (aw_addr_r == WWC_OFF_WAKE);
   wire wr_cfg = do_write && w_strb_r[0] && (aw_addr_r == WWC_OFF_CFG);
   wire wr_hit = (aw_addr_r <= WWC_OFF_CFG) && (aw_addr_r[1:0] == 2'h0);
   wire rd_hit = (axi_req.araddr <= WWC_OFF_CFG) && (axi_req.araddr[1:0] == 2'h0);
   wire [7:0] flags_rd = {idle_keep_r, 6'h00, key_flag_r};
   wire [7:0] stat_rd = {1'h0, mode_r, slow_rdy_r, fast_rdy_r, pdf_r, to_r};
   wire [7:0] rd_byte = (axi_req.araddr == WWC_OFF_CTRL) ? ctrl_r :
                        (axi_req.araddr == WWC_OFF_FLAGS) ? flags_rd :
                        (axi_req.araddr == WWC_OFF_STAT) ? stat_rd :
                        (axi_req.araddr == WWC_OFF_WAKE) ? wake_en_r :
                        (axi_req.araddr == WWC_OFF_CFG) ? {6'h00, cfg_r} : 8'h00;
   // a bad key also snaps the control register back to its power-on value
   assign ctrl_nxt = key_fire ? WWC_CTRL_POR : (wr_ctrl ? w_data_r[7:0] : ctrl_r);
   // writing one leaves the flag alone; only a written zero clears it
   assign key_flag_nxt = key_fire || (key_flag_r && !(wr_flags && !w_data_r[WWC_FLG_KEYRST]));

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= WWC_CTRL_POR;
         key_flag_r <= 1'h0;
         idle_keep_r <= 1'h0;
         wake_en_r <= WWC_WAKE_POR;
         cfg_r <= WWC_CFG_POR;
      end else begin
         ctrl_r <= ctrl_nxt;
         key_flag_r <= key_flag_nxt;
         idle_keep_r <= wr_flags ? w_data_r[WWC_FLG_IDLEKEEP] : idle_keep_r;
         wake_en_r <= wr_wake ? w_data_r[7:0] : wake_en_r;
         cfg_r <= wr_cfg ? w_data_r[1:0] : cfg_r;
      end
   end

   // ****************************************
   // write channels
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'h0;
         w_got_r <= 1'h0;
         aw_addr_r <= '0;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         axi_rsp.awready <= 1'h0;
         axi_rsp.wready <= 1'h0;
         axi_rsp.bvalid <= 1'h0;
         axi_rsp.bresp <= WWC_RESP_OK;
         axi_rsp.arready <= 1'h0;
         axi_rsp.rvalid <= 1'h0;
         axi_rsp.rdata <= 32'h0;
         axi_rsp.rresp <= WWC_RESP_OK;
      end else begin
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         aw_addr_r <= aw_take ? axi_req.awaddr : aw_addr_r;
         w_data_r <= w_take ? axi_req.wdata : w_data_r;
         w_strb_r <= w_take ? axi_req.wstrb : w_strb_r;
         axi_rsp.awready <= !aw_got_nxt;
         axi_rsp.wready <= !w_got_nxt;
         axi_rsp.bvalid <= do_write || (axi_rsp.bvalid && !b_done);
         axi_rsp.bresp <= do_write ? (wr_hit ? WWC_RESP_OK : WWC_RESP_ERR) : axi_rsp.bresp;
         // read side lives here too so the response struct has a single driver
         axi_rsp.arready <= !ar_take && (rd_done || !axi_rsp.rvalid);
         axi_rsp.rvalid <= ar_take || (axi_rsp.rvalid && !rd_done);
         axi_rsp.rdata <= ar_take ? {24'h000000, rd_byte} : axi_rsp.rdata;
         axi_rsp.rresp <= ar_take ? (rd_hit ? WWC_RESP_OK : WWC_RESP_ERR) : axi_rsp.rresp;
      end
   end

endmodule

/* test/wwc_top_asserts.sv */
`timescale 1ns/10ps

module wwc_top_asserts (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire wwc_pkg::wwc_axi_req_s axi_req,
   input wire wwc_pkg::wwc_axi_rsp_s axi_rsp,
   // processor side
   input wire logic halt_instruction,
   input wire logic stack_full,
   // control outputs
   input wire logic dev_reset,
   input wire logic pc_sp_reset,
   input wire logic wake_resume,
   input wire logic wake_vector,
   input wire logic cpu_run,
   input wire logic fast_osc_ready_flag
);
   import wwc_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ****************************************
   // helpers
   // ****************************************
   // write of an undefined key; the delay window assumes a sub clock of 8 aclk
   wire logic wr_both = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   wire logic bad_key_wr = wr_both && axi_req.awaddr == WWC_OFF_CTRL && axi_req.wstrb[0] &&
      axi_req.wdata[7:3] != WWC_KEY_EN && axi_req.wdata[7:3] != WWC_KEY_DIS;

   // ****************************************
   // properties
   // ****************************************
   property p_run_fast;
      cpu_run |-> fast_osc_ready_flag;
   endproperty
   a_run_fast: assert property (p_run_fast)
      else $error("cpu runs without fast oscillator ready");
   property p_bad_key;
      bad_key_wr |-> ##[10:40] dev_reset;
   endproperty
   a_bad_key: assert property (p_bad_key)
      else $error("bad key gave no device reset in time");
   property p_dev_pulse;
      dev_reset |=> !dev_reset;
   endproperty
   a_dev_pulse: assert property (p_dev_pulse)
      else $error("device reset longer than one cycle");
   property p_pcsp_only;
      pc_sp_reset |-> !dev_reset && !wake_resume && !wake_vector;
   endproperty
   a_pcsp_only: assert property (p_pcsp_only)
      else $error("sleep overflow mixed with another wake action");
   property p_resume_run;
      wake_resume |=> cpu_run;
   endproperty
   a_resume_run: assert property (p_resume_run)
      else $error("resume did not restart the processor");
   property p_vector_free;
      wake_vector |-> !stack_full ##1 cpu_run;
   endproperty
   a_vector_free: assert property (p_vector_free)
      else $error("vector wake with full stack or no restart");
   property p_wake_asleep;
      (wake_resume || wake_vector || pc_sp_reset) |-> !cpu_run;
   endproperty
   a_wake_asleep: assert property (p_wake_asleep)
      else $error("wake pulse while running");
   property p_halt_stop;
      halt_instruction && cpu_run |-> ##[1:3] !cpu_run;
   endproperty
   a_halt_stop: assert property (p_halt_stop)
      else $error("halt did not stop the processor");
   property p_read_lat;
      axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid;
   endproperty
   a_read_lat: assert property (p_read_lat)
      else $error("read data not one cycle after address");
   property p_write_lat;
      wr_both |-> ##[1:2] axi_rsp.bvalid;
   endproperty
   a_write_lat: assert property (p_write_lat)
      else $error("write response late");
endmodule

/* test/tb_top.sv */
`timescale 1ns/10ps

module tb_top;
   import wwc_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   wwc_axi_req_s req = '{wstrb: 4'hf, bready: 1'b1, rready: 1'b1, default: '0};
   wwc_axi_rsp_s rsp;
   logic rc_osc = 1'b0;
   logic [2:0] div_r = 3'h0;
   logic clr_i = 1'b0;
   logic halt_i = 1'b0;
   logic idle_sel = 1'b0;
   logic [7:0] irq = 8'h00;
   logic [7:0] irq_en = 8'h00;
   logic stack_full = 1'b0;
   logic [7:0] porta = 8'hff;
   logic ext_rst_n = 1'b1;
   logic dev_reset, pc_sp_reset, wake_resume, wake_vector, cpu_run, fast_rdy;
   wire [3:0] outs = {dev_reset, pc_sp_reset, wake_resume, wake_vector};
   int err_count = 0;
   int checked = 0;

   wwc_top i_dut (
      .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .slow_crystal_osc(div_r[2]), .slow_rc_osc(rc_osc),
      .clear_watchdog_instruction(clr_i), .halt_instruction(halt_i), .idle_mode_sel(idle_sel),
      .irq_req(irq), .irq_en(irq_en), .stack_full(stack_full), .porta_in(porta), .ext_reset_n(ext_rst_n),
      .dev_reset(dev_reset), .pc_sp_reset(pc_sp_reset), .wake_resume(wake_resume),
      .wake_vector(wake_vector), .cpu_run(cpu_run), .fast_osc_ready_flag(fast_rdy)
   );

   // clock, and a sub clock of 8 aclk so long periods stay short
   initial begin
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      div_r <= div_r + 3'h1;
      rc_osc <= div_r[2];
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic final_report();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // a bus wait that runs out ends the run
   task automatic bus_to(input int n);
      if (n >= 200) begin
         chk("bus answer", 1, 0);
         final_report();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      req.awaddr <= a;
      req.wdata <= {24'h0, d};
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
         if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
      end while (!rsp.bvalid && n < 200);
      bus_to(n);
      chk("bresp", WWC_RESP_OK, rsp.bresp);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input logic [1:0] r);
      int n;
      n = 0;
      req.araddr <= a;
      req.arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (rsp.arready && req.arvalid) req.arvalid <= 1'b0;
      end while (!rsp.rvalid && n < 200);
      bus_to(n);
      chk("rresp", r, rsp.rresp);
      chk("rdata", e, rsp.rdata & {24'h0, m});
   endtask

   // waits are bounded; a caller expecting no pulse checks for zero
   task automatic wait_out(input logic [3:0] m, input int lim, output logic [3:0] seen, output int cyc);
      seen = 4'h0;
      for (cyc = 0; cyc < lim && seen == 4'h0; cyc++) begin
         @(posedge aclk);
         seen = outs & m;
      end
   endtask

   // two idle edges first so the processor is running again after a wake
   task automatic instr(input logic [1:0] v);
      repeat (2) @(posedge aclk);
      {halt_i, clr_i} <= v;
      @(posedge aclk);
      {halt_i, clr_i} <= 2'b00;
   endtask

   // ****************************************
   // sequence
   // ****************************************
   initial begin
      logic [3:0] seen;
      int cyc;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      // reset values and an unmapped read
      rd_chk(WWC_OFF_CTRL, 8'hff, WWC_CTRL_POR, WWC_RESP_OK);
      rd_chk(WWC_OFF_FLAGS, 8'hff, 8'h00, WWC_RESP_OK);
      rd_chk(WWC_OFF_STAT, 8'h03, 8'h00, WWC_RESP_OK);
      rd_chk(8'h14, 8'hff, 8'h00, WWC_RESP_ERR);
      // undefined key, then the flag only software may clear
      wr(WWC_OFF_CTRL, 8'h03);
      wait_out(4'h8, 60, seen, cyc);
      chk("key reset", 4'h8, seen);
      chk("key reset delay", 1, cyc >= 12 && cyc <= 30);
      rd_chk(WWC_OFF_FLAGS, 8'h01, 8'h01, WWC_RESP_OK);
      rd_chk(WWC_OFF_CTRL, 8'hff, WWC_CTRL_POR, WWC_RESP_OK);
      wr(WWC_OFF_FLAGS, 8'h01);
      rd_chk(WWC_OFF_FLAGS, 8'h01, 8'h01, WWC_RESP_OK);
      wr(WWC_OFF_FLAGS, 8'h00);
      rd_chk(WWC_OFF_FLAGS, 8'h01, 8'h00, WWC_RESP_OK);
      // overflow while running, two periods, clear holding it off
      for (int s = 0; s < 2; s++) begin
         wr(WWC_OFF_CTRL, {WWC_KEY_EN, 3'(s)});
         instr(2'b01);
         wait_out(4'h8, 1800, seen, cyc);
         chk("early overflow", 4'h0, seen);
         instr(2'b01);
         wait_out(4'hc, (258 << (2 * s)) * 8, seen, cyc);
         chk("overflow reset", 4'h8, seen);
         chk("overflow period", 1, cyc >= ((256 << (2 * s)) - 1) * 8 && cyc <= ((256 << (2 * s)) + 2) * 8);
         rd_chk(WWC_OFF_STAT, 8'h03, 8'h01, WWC_RESP_OK);
      end
      instr(2'b01);
      rd_chk(WWC_OFF_STAT, 8'h03, 8'h00, WWC_RESP_OK);
      // overflow in idle resets pc and sp only
      wr(WWC_OFF_CTRL, {WWC_KEY_EN, 3'h0});
      idle_sel <= 1'b1;
      instr(2'b10);
      rd_chk(WWC_OFF_STAT, 8'h73, 8'h32, WWC_RESP_OK);
      wait_out(4'hf, 2200, seen, cyc);
      chk("idle overflow", 4'h4, seen);
      chk("idle period", 1, cyc >= 1990 && cyc <= 2080);
      rd_chk(WWC_OFF_STAT, 8'h03, 8'h03, WWC_RESP_OK);
      // disabled watchdog, port A wake on enabled pin only
      wr(WWC_OFF_CTRL, 8'ha8);
      wr(WWC_OFF_WAKE, 8'h04);
      rd_chk(WWC_OFF_WAKE, 8'hff, 8'h04, WWC_RESP_OK);
      instr(2'b10);
      porta <= 8'hf7;
      wait_out(4'hf, 2200, seen, cyc);
      chk("no wake", 4'h0, seen);
      porta <= 8'hf3;
      wait_out(4'hf, 20, seen, cyc);
      chk("port wake", 4'h2, seen);
      porta <= 8'hff;
      // interrupt wake: disabled, enabled, enabled with full stack
      for (int i = 0; i < 3; i++) begin
         irq_en <= {7'h0, i != 0};
         stack_full <= (i == 2);
         instr(2'b10);
         irq <= 8'h01;
         wait_out(4'hf, 20, seen, cyc);
         chk("irq wake", i == 1 ? 4'h1 : 4'h2, seen);
         irq <= 8'h00;
      end
      // request already set at entry cannot wake; external reset can; idle keeps the system clock
      @(posedge aclk);
      irq <= 8'h02;
      wr(WWC_OFF_FLAGS, 8'h80);
      instr(2'b10);
      rd_chk(WWC_OFF_STAT, 8'h70, 8'h40, WWC_RESP_OK);
      wait_out(4'hf, 30, seen, cyc);
      chk("pending irq", 4'h0, seen);
      ext_rst_n <= 1'b0;
      wait_out(4'hf, 20, seen, cyc);
      chk("ext wake", 4'h8, seen);
      ext_rst_n <= 1'b1;
      irq <= 8'h00;
      // the detector alone keeps the sub clock running in sleep
      idle_sel <= 1'b0;
      wr(WWC_OFF_CFG, 8'h02);
      instr(2'b10);
      rd_chk(WWC_OFF_STAT, 8'h70, 8'h20, WWC_RESP_OK);
      porta <= 8'hfb;
      wait_out(4'hf, 20, seen, cyc);
      chk("sub sleep wake", 4'h2, seen);
      porta <= 8'hff;
      // deepest sleep waits for the fast oscillator; the slow crystal starts after it
      wr(WWC_OFF_CFG, 8'h01);
      instr(2'b10);
      rd_chk(WWC_OFF_STAT, 8'h70, 8'h10, WWC_RESP_OK);
      chk("fast ready asleep", 0, fast_rdy);
      porta <= 8'hfb;
      wait_out(4'h2, 1300, seen, cyc);
      chk("deep wake", 4'h2, seen);
      chk("deep wake delay", 1, cyc >= 1024);
      chk("fast ready", 1, fast_rdy);
      @(posedge aclk);
      chk("cpu run", 1, cpu_run);
      rd_chk(WWC_OFF_STAT, 8'h0c, 8'h04, WWC_RESP_OK);
      final_report();
   end
endmodule

bind wwc_top wwc_top_asserts i_chk (
   .aclk, .aresetn, .axi_req, .axi_rsp, .halt_instruction, .stack_full, .dev_reset, .pc_sp_reset,
   .wake_resume, .wake_vector, .cpu_run, .fast_osc_ready_flag
);
